// >>> core/mapper_cfg.svh
// Constants of the expansion I/O address mapper
`ifndef MAPPER_CFG_SVH
`define MAPPER_CFG_SVH

// ****
// Limits, bank numbers, lane words, error codes
// ****
`define CFG_POINT_LIMIT   14'd256
`define CFG_WORD_LIMIT    14'd64
`define CFG_MAX_MODULES   6'd32
`define CFG_SLOTS         33
`define CFG_BANK_WORDS    64

`define CFG_IN_BANK_BASE  12'hf00
`define CFG_OUT_BANK_BASE 12'hf40
`define CFG_BANK_SEL_IN   6'h3c
`define CFG_BANK_SEL_OUT  6'h3d

`define CFG_WORDS_SINGLE  4'h1
`define CFG_WORDS_DIGIT   4'h8
`define CFG_WORDS_DISP0_D 4'h3
`define CFG_WORDS_DISP1_D 4'h2
`define CFG_WORDS_DISP_ND 4'h4

`define CFG_ERR_NONE      4'h0
`define CFG_ERR_DI_OVER   4'h1
`define CFG_ERR_DO_OVER   4'h2
`define CFG_ERR_NI_OVER   4'h3
`define CFG_ERR_NO_OVER   4'h4
`define CFG_ERR_MODULES   4'h5
`define CFG_ERR_NO_MAIN   4'h6
`define CFG_PRIME_CYCLES  2'h2

`endif

// >>> core/mapper_pkg.sv
// Types of the expansion I/O address mapper
package mapper_pkg;

  typedef enum logic [2:0] {
    ST_IDENT = 3'b001,
    ST_RUN   = 3'b010,
    ST_FAULT = 3'b100
  } map_state_e;

  typedef enum logic [2:0] {
    CMD_IDLE     = 3'h0,
    CMD_IDENT    = 3'h1,
    CMD_RD_POINT = 3'h2,
    CMD_WR_POINT = 3'h3,
    CMD_RD_WORD  = 3'h4,
    CMD_WR_WORD  = 3'h5
  } exp_cmd_e;

  typedef enum logic [3:0] {
    KIND_DIGITAL    = 4'h0,
    KIND_ANALOG_IN  = 4'h1,
    KIND_ANALOG_OUT = 4'h2,
    KIND_ANALOG_MIX = 4'h3,
    KIND_DIGIT_SW   = 4'h4,
    KIND_SEG_DISP   = 4'h5,
    KIND_TEMP_IN    = 4'h6
  } mod_kind_e;

  typedef enum logic [1:0] {
    PH_DI  = 2'h0,
    PH_DO  = 2'h1,
    PH_IN  = 2'h2,
    PH_OUT = 2'h3
  } scan_phase_e;

endpackage : mapper_pkg

// >>> core/word_bank.sv
// Sixty-four word bank with one write port and a registered read port
`timescale 1ns/10ps
`default_nettype none
`include "mapper_cfg.svh"

module word_bank (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  // Write port
  input  wire logic        wr_en_in,
  input  wire logic [5:0]  wr_addr_in,
  input  wire logic [15:0] wr_data_in,
  // Read port
  input  wire logic [5:0]  rd_addr_in,
  output logic      [15:0] rd_data_out
);

  logic [15:0] mem [`CFG_BANK_WORDS];
  logic [15:0] rd_data_ff;
  logic [15:0] nxt_rd_data;

  // No reset on the array: contents are undefined until first written
  always_ff @(posedge clock_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_comb begin
    nxt_rd_data = mem[rd_addr_in];
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_ff <= 16'h0000;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data_out = rd_data_ff;

endmodule : word_bank
`default_nettype wire

// >>> core/expansion_io_address_mapper.sv
// Expansion I/O address mapper: cascade discovery, point numbering, word bank transfer
//
// Function
// - 256 input and 256 output points, numbered 0 to 255.
// - Output terminals show coils; input points follow input terminals.
// - Expansion local point indices start at 1.
// - Absolute point number: earlier point counts plus local index, less one on expansions.
// - Each lane word is one unsigned 16-bit value.
// - Input bank: 64 words, registers 3840 to 3903, from input lanes.
// - Output bank: 64 words, registers 3904 to 3967, to output lanes.
// - Lane word is a magnitude or BCD value, passed unchanged.
// - Words per lane follow module kind and display mode.
// - Word allocation starts at the first expansion module.
// - Input lanes from 3840, each after the previous lane's words.
// - Output lanes from 3904, each after the previous lane's words.
// - Each direction's accumulation ignores points and the other direction.
// - Module kinds and lane counts are detected at startup.
// - Scan copies input lanes to bank and bank to output lanes.
// - Over limits or over 32 modules: error flag and code.
`timescale 1ns/10ps
`default_nettype none
`include "mapper_cfg.svh"

module expansion_io_address_mapper (
  // Clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  rstn_in,
  // Expansion bus requests
  output logic      [5:0]            exp_slot_out,
  output var mapper_pkg::exp_cmd_e   exp_cmd_out,
  output logic      [7:0]            exp_index_out,
  output logic      [2:0]            exp_word_out,
  output logic      [15:0]           exp_wdata_out,
  // Expansion bus answers
  input  wire logic                  exp_ack_in,
  input  wire logic                  exp_present_in,
  input  wire mapper_pkg::mod_kind_e exp_kind_in,
  input  wire logic                  exp_decode_in,
  input  wire logic [7:0]            exp_di_count_in,
  input  wire logic [7:0]            exp_do_count_in,
  input  wire logic [3:0]            exp_in_lanes_in,
  input  wire logic [3:0]            exp_out_lanes_in,
  input  wire logic [15:0]           exp_rdata_in,
  // Point image toward the controller core
  output logic      [255:0]          input_points_out,
  input  wire logic [255:0]          coil_points_in,
  // Word register port toward the controller core
  input  wire logic [11:0]           reg_addr_in,
  input  wire logic                  reg_rd_in,
  input  wire logic                  reg_wr_in,
  input  wire logic [15:0]           reg_wdata_in,
  output logic      [15:0]           reg_rdata_out,
  output logic                       reg_rvalid_out,
  // Status
  output logic                       map_ready_out,
  output logic                       scan_done_out,
  output logic                       error_out,
  output logic      [3:0]            error_code_out,
  output logic      [5:0]            module_count_out
);

  import mapper_pkg::*;

  // ****
  // Lane word counts
  // ****
  function automatic logic [3:0] lane_words(input mod_kind_e k, input logic dec,
                                            input logic [3:0] lane, input logic out_dir);
    logic [3:0] w;
    w = 4'h0;
    case (k)
      KIND_ANALOG_IN, KIND_TEMP_IN: w = out_dir ? 4'h0 : `CFG_WORDS_SINGLE;
      KIND_ANALOG_OUT: w = out_dir ? `CFG_WORDS_SINGLE : 4'h0;
      KIND_ANALOG_MIX: w = `CFG_WORDS_SINGLE;
      KIND_DIGIT_SW:   w = out_dir ? 4'h0 : `CFG_WORDS_DIGIT;
      KIND_SEG_DISP: begin
        if (out_dir) begin
          w = !dec ? `CFG_WORDS_DISP_ND : ((lane == 4'h0) ? `CFG_WORDS_DISP0_D : `CFG_WORDS_DISP1_D);
        end
      end
      default: w = 4'h0;
    endcase
    return w;
  endfunction : lane_words

  function automatic logic [7:0] lanes_total(input mod_kind_e k, input logic dec,
                                             input logic [3:0] lanes, input logic out_dir);
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 0; i < 16; i++) begin
      if (i < lanes) begin
        sum = sum + {4'h0, lane_words(k, dec, 4'(i), out_dir)};
      end
    end
    return sum;
  endfunction : lanes_total

  // ****
  // State
  // ****
  map_state_e  state_ff, nxt_state;
  scan_phase_e phase_ff, nxt_phase;
  logic [5:0]  slot_ff, nxt_slot;
  logic [5:0]  nslots_ff, nxt_nslots;
  logic [7:0]  idx_ff, nxt_idx;
  logic [2:0]  word_ff, nxt_word;
  logic [7:0]  wc_ff, nxt_wc;
  logic [1:0]  pr_ff, nxt_pr;
  logic [13:0] acc_di_ff, nxt_acc_di, acc_do_ff, nxt_acc_do;
  logic [13:0] acc_in_ff, nxt_acc_in, acc_out_ff, nxt_acc_out;
  logic [255:0] points_ff, nxt_points;
  logic [15:0] wdata_ff, nxt_wdata;
  logic        error_ff, nxt_error;
  logic [3:0]  code_ff, nxt_code;
  logic        done_ff, nxt_done;
  logic        rvalid_ff, nxt_rvalid;

  mod_kind_e   kind_ff    [`CFG_SLOTS], nxt_kind    [`CFG_SLOTS];
  logic        dec_ff     [`CFG_SLOTS], nxt_dec     [`CFG_SLOTS];
  logic [7:0]  di_cnt_ff  [`CFG_SLOTS], nxt_di_cnt  [`CFG_SLOTS];
  logic [7:0]  do_cnt_ff  [`CFG_SLOTS], nxt_do_cnt  [`CFG_SLOTS];
  logic [3:0]  inl_ff     [`CFG_SLOTS], nxt_inl     [`CFG_SLOTS];
  logic [3:0]  outl_ff    [`CFG_SLOTS], nxt_outl    [`CFG_SLOTS];
  logic [7:0]  di_base_ff [`CFG_SLOTS], nxt_di_base [`CFG_SLOTS];
  logic [7:0]  do_base_ff [`CFG_SLOTS], nxt_do_base [`CFG_SLOTS];
  logic [5:0]  in_base_ff [`CFG_SLOTS], nxt_in_base [`CFG_SLOTS];
  logic [5:0]  out_base_ff[`CFG_SLOTS], nxt_out_base[`CFG_SLOTS];

  logic [7:0]  tot_in, tot_out, abs_di, abs_do, lane_cnt;
  logic [3:0]  w_cur;
  logic        item_valid, is_out, in_wr_en;
  logic [5:0]  in_addr, out_addr;
  logic [15:0] in_q, out_q;

  // ****
  // Current item
  // ****
  always_comb begin
    is_out     = (phase_ff == PH_OUT);
    w_cur      = lane_words(kind_ff[slot_ff], dec_ff[slot_ff], idx_ff[3:0], is_out);
    abs_di     = di_base_ff[slot_ff] + idx_ff;
    abs_do     = do_base_ff[slot_ff] + idx_ff;
    in_addr    = in_base_ff[slot_ff] + wc_ff[5:0];
    out_addr   = out_base_ff[slot_ff] + wc_ff[5:0];
    lane_cnt   = {4'h0, is_out ? outl_ff[slot_ff] : inl_ff[slot_ff]};
    item_valid = 1'b0;
    case (phase_ff)
      PH_DI:   item_valid = idx_ff < di_cnt_ff[slot_ff];
      PH_DO:   item_valid = idx_ff < do_cnt_ff[slot_ff];
      default: item_valid = idx_ff < lane_cnt;
    endcase
    tot_in  = (slot_ff == 6'h00) ? 8'h00 : lanes_total(exp_kind_in, exp_decode_in, exp_in_lanes_in, 1'b0);
    tot_out = (slot_ff == 6'h00) ? 8'h00 : lanes_total(exp_kind_in, exp_decode_in, exp_out_lanes_in, 1'b1);
  end

  // ****
  // Discovery and scan sequencing
  // ****
  always_comb begin
    nxt_state = state_ff;   nxt_phase  = phase_ff;  nxt_slot   = slot_ff;
    nxt_nslots = nslots_ff; nxt_idx    = idx_ff;    nxt_word   = word_ff;
    nxt_wc    = wc_ff;      nxt_pr     = pr_ff;     nxt_points = points_ff;
    nxt_acc_di = acc_di_ff; nxt_acc_do = acc_do_ff;
    nxt_acc_in = acc_in_ff; nxt_acc_out = acc_out_ff;
    nxt_wdata = wdata_ff;   nxt_error  = error_ff;  nxt_code   = code_ff;
    nxt_done  = 1'b0;       in_wr_en   = 1'b0;
    nxt_kind = kind_ff;     nxt_dec = dec_ff;       nxt_di_cnt = di_cnt_ff; nxt_do_cnt = do_cnt_ff;
    nxt_inl = inl_ff;       nxt_outl = outl_ff;     nxt_di_base = di_base_ff; nxt_do_base = do_base_ff;
    nxt_in_base = in_base_ff; nxt_out_base = out_base_ff;
    nxt_rvalid = reg_rd_in && (reg_addr_in[11:6] == `CFG_BANK_SEL_IN);
    case (state_ff)
      ST_IDENT: begin
        if (exp_ack_in) begin
          if (!exp_present_in) begin
            nxt_nslots = slot_ff;
            nxt_state  = ST_FAULT;
            nxt_error  = 1'b1;
            if (slot_ff == 6'h00) begin
              nxt_code = `CFG_ERR_NO_MAIN;
            end else if (acc_di_ff > `CFG_POINT_LIMIT) begin
              nxt_code = `CFG_ERR_DI_OVER;
            end else if (acc_do_ff > `CFG_POINT_LIMIT) begin
              nxt_code = `CFG_ERR_DO_OVER;
            end else if (acc_in_ff > `CFG_WORD_LIMIT) begin
              nxt_code = `CFG_ERR_NI_OVER;
            end else if (acc_out_ff > `CFG_WORD_LIMIT) begin
              nxt_code = `CFG_ERR_NO_OVER;
            end else begin
              nxt_error = 1'b0;
              nxt_state = ST_RUN;
              nxt_slot  = 6'h00;
            end
          end else if (slot_ff == `CFG_MAX_MODULES + 6'h01) begin
            nxt_nslots = slot_ff;
            nxt_state  = ST_FAULT;
            nxt_error  = 1'b1;
            nxt_code   = `CFG_ERR_MODULES;
          end else begin
            // Bases are the totals so far; each direction keeps its own sum
            nxt_kind[slot_ff]     = exp_kind_in;
            nxt_dec[slot_ff]      = exp_decode_in;
            nxt_di_cnt[slot_ff]   = exp_di_count_in;
            nxt_do_cnt[slot_ff]   = exp_do_count_in;
            nxt_inl[slot_ff]      = (tot_in == 8'h00) ? 4'h0 : exp_in_lanes_in;
            nxt_outl[slot_ff]     = (tot_out == 8'h00) ? 4'h0 : exp_out_lanes_in;
            nxt_di_base[slot_ff]  = acc_di_ff[7:0];
            nxt_do_base[slot_ff]  = acc_do_ff[7:0];
            nxt_in_base[slot_ff]  = acc_in_ff[5:0];
            nxt_out_base[slot_ff] = acc_out_ff[5:0];
            nxt_acc_di  = acc_di_ff + {6'h00, exp_di_count_in};
            nxt_acc_do  = acc_do_ff + {6'h00, exp_do_count_in};
            nxt_acc_in  = acc_in_ff + {6'h00, tot_in};
            nxt_acc_out = acc_out_ff + {6'h00, tot_out};
            nxt_slot    = slot_ff + 6'h01;
          end
        end
      end
      ST_RUN: begin
        if (!item_valid) begin
          nxt_idx  = 8'h00;
          nxt_word = 3'h0;
          nxt_wc   = 8'h00;
          nxt_pr   = 2'h0;
          if (phase_ff == PH_OUT) begin
            nxt_phase = PH_DI;
            if (slot_ff + 6'h01 == nslots_ff) begin
              nxt_slot = 6'h00;
              nxt_done = 1'b1;
            end else begin
              nxt_slot = slot_ff + 6'h01;
            end
          end else begin
            nxt_phase = scan_phase_e'(phase_ff + 2'h1);
          end
        end else if (pr_ff != `CFG_PRIME_CYCLES) begin
          // Two idle cycles let the output bank's registered read settle
          nxt_pr = pr_ff + 2'h1;
          if (pr_ff == 2'h1) begin
            nxt_wdata = (phase_ff == PH_DO) ? {15'h0000, coil_points_in[abs_do]} : out_q;
          end
        end else if (exp_ack_in) begin
          nxt_pr = 2'h0;
          if (phase_ff == PH_DI) begin
            nxt_points[abs_di] = exp_rdata_in[0];
          end
          if (phase_ff == PH_IN) begin
            in_wr_en = 1'b1;
          end
          if (phase_ff == PH_DI || phase_ff == PH_DO || {1'b0, word_ff} + 4'h1 >= w_cur) begin
            nxt_idx  = idx_ff + 8'h01;
            nxt_word = 3'h0;
          end else begin
            nxt_word = word_ff + 3'h1;
          end
          if (phase_ff == PH_IN || phase_ff == PH_OUT) begin
            nxt_wc = wc_ff + 8'h01;
          end
        end
      end
      default: begin
        nxt_state = ST_FAULT; // Held until reset
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff <= ST_IDENT;  phase_ff <= PH_DI;  slot_ff <= 6'h00;  nslots_ff <= 6'h00;
      idx_ff <= 8'h00;       word_ff <= 3'h0;    wc_ff <= 8'h00;    pr_ff <= 2'h0;
      acc_di_ff <= 14'h0000; acc_do_ff <= 14'h0000;
      acc_in_ff <= 14'h0000; acc_out_ff <= 14'h0000;
      points_ff <= '0;       wdata_ff <= 16'h0000;
      error_ff <= 1'b0;      code_ff <= `CFG_ERR_NONE;
      done_ff <= 1'b0;       rvalid_ff <= 1'b0;
      for (int i = 0; i < `CFG_SLOTS; i++) begin
        kind_ff[i] <= KIND_DIGITAL; dec_ff[i] <= 1'b0;
        di_cnt_ff[i] <= 8'h00;      do_cnt_ff[i] <= 8'h00;
        inl_ff[i] <= 4'h0;          outl_ff[i] <= 4'h0;
        di_base_ff[i] <= 8'h00;     do_base_ff[i] <= 8'h00;
        in_base_ff[i] <= 6'h00;     out_base_ff[i] <= 6'h00;
      end
    end else begin
      state_ff <= nxt_state;   phase_ff <= nxt_phase; slot_ff <= nxt_slot; nslots_ff <= nxt_nslots;
      idx_ff <= nxt_idx;       word_ff <= nxt_word;   wc_ff <= nxt_wc;     pr_ff <= nxt_pr;
      acc_di_ff <= nxt_acc_di; acc_do_ff <= nxt_acc_do;
      acc_in_ff <= nxt_acc_in; acc_out_ff <= nxt_acc_out;
      points_ff <= nxt_points; wdata_ff <= nxt_wdata;
      error_ff <= nxt_error;   code_ff <= nxt_code;
      done_ff <= nxt_done;     rvalid_ff <= nxt_rvalid;
      kind_ff <= nxt_kind;     dec_ff <= nxt_dec;
      di_cnt_ff <= nxt_di_cnt; do_cnt_ff <= nxt_do_cnt;
      inl_ff <= nxt_inl;       outl_ff <= nxt_outl;
      di_base_ff <= nxt_di_base; do_base_ff <= nxt_do_base;
      in_base_ff <= nxt_in_base; out_base_ff <= nxt_out_base;
    end
  end

  // ****
  // Word banks
  // ****
  // Core reads reach only the input bank; the output bank read port serves the scan
  word_bank u_in_bank (
    .clock_in    (clock_in),
    .rstn_in     (rstn_in),
    .wr_en_in    (in_wr_en),
    .wr_addr_in  (in_addr),
    .wr_data_in  (exp_rdata_in),
    .rd_addr_in  (reg_addr_in[5:0]),
    .rd_data_out (in_q)
  );

  word_bank u_out_bank (
    .clock_in    (clock_in),
    .rstn_in     (rstn_in),
    .wr_en_in    (reg_wr_in && (reg_addr_in[11:6] == `CFG_BANK_SEL_OUT)),
    .wr_addr_in  (reg_addr_in[5:0]),
    .wr_data_in  (reg_wdata_in),
    .rd_addr_in  (out_addr),
    .rd_data_out (out_q)
  );

  // ****
  // Outputs
  // ****
  always_comb begin
    exp_cmd_out = CMD_IDLE;
    if (state_ff == ST_IDENT) begin
      exp_cmd_out = CMD_IDENT;
    end else if (state_ff == ST_RUN && item_valid && pr_ff == `CFG_PRIME_CYCLES) begin
      case (phase_ff)
        PH_DI:   exp_cmd_out = CMD_RD_POINT;
        PH_DO:   exp_cmd_out = CMD_WR_POINT;
        PH_IN:   exp_cmd_out = CMD_RD_WORD;
        default: exp_cmd_out = CMD_WR_WORD;
      endcase
    end
  end

  assign exp_slot_out     = slot_ff;
  assign exp_index_out    = (slot_ff != 6'h00 && (phase_ff == PH_DI || phase_ff == PH_DO)) ?
                            idx_ff + 8'h01 : idx_ff;
  assign exp_word_out     = word_ff;
  assign exp_wdata_out    = wdata_ff;
  assign input_points_out = points_ff;
  assign reg_rdata_out    = in_q;
  assign reg_rvalid_out   = rvalid_ff;
  assign map_ready_out    = (state_ff == ST_RUN);
  assign scan_done_out    = done_ff;
  assign error_out        = error_ff;
  assign error_code_out   = code_ff;
  assign module_count_out = nslots_ff;

endmodule : expansion_io_address_mapper
`default_nettype wire

// >>> testbench/expansion_io_address_mapper_asserts.sv
// Port checker of the expansion I/O address mapper
`timescale 1ns/10ps
`default_nettype none
module expansion_io_address_mapper_asserts (
  // Clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 rstn_in,
  // Expansion bus
  input  wire logic [5:0]           exp_slot_out,
  input  wire mapper_pkg::exp_cmd_e exp_cmd_out,
  input  wire logic [7:0]           exp_index_out,
  input  wire logic [2:0]           exp_word_out,
  input  wire logic [15:0]          exp_wdata_out,
  input  wire logic                 exp_ack_in,
  // Register port and status
  input  wire logic [11:0]          reg_addr_in,
  input  wire logic                 reg_rd_in,
  input  wire logic                 reg_rvalid_out,
  input  wire logic                 map_ready_out,
  input  wire logic                 scan_done_out,
  input  wire logic                 error_out,
  input  wire logic [3:0]           error_code_out,
  input  wire logic [5:0]           module_count_out
);
  import mapper_pkg::*;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // ****
  // Handshake, bank reads, map and faults
  // ****
  sequence s_held_req;
    exp_cmd_out != CMD_IDLE && !exp_ack_in;
  endsequence
  sequence s_req_same;
    $stable(exp_cmd_out) && $stable(exp_slot_out) && $stable(exp_index_out) && $stable(exp_word_out)
      && $stable(exp_wdata_out);
  endsequence
  req_hold_a: assert property (s_held_req |=> s_req_same) else $error("request changed before ack");
  word_slot_a: assert property (exp_cmd_out inside {CMD_RD_WORD, CMD_WR_WORD}
    |-> exp_slot_out != 6'h0 && exp_slot_out <= 6'h20) else $error("word request to main unit");
  scan_pulse_a: assert property (scan_done_out |=> !scan_done_out) else $error("scan done too long");
  in_read_a: assert property (reg_rd_in && reg_addr_in >= 12'hf00 && reg_addr_in <= 12'hf3f
    |=> reg_rvalid_out) else $error("input bank read not answered");
  out_noread_a: assert property (reg_rd_in && !(reg_addr_in >= 12'hf00 && reg_addr_in <= 12'hf3f)
    |=> !reg_rvalid_out) else $error("stray read answered");
  map_fixed_a: assert property (map_ready_out |=> map_ready_out && $stable(module_count_out))
    else $error("map changed after discovery");
  no_rescan_a: assert property (map_ready_out |-> exp_cmd_out != CMD_IDENT)
    else $error("discovery repeated");
  err_sticky_a: assert property (error_out |=> error_out && $stable(error_code_out))
    else $error("error not sticky");
  err_code_a: assert property (error_out |-> error_code_out != 4'h0 && !map_ready_out && !scan_done_out)
    else $error("fault without code");
endmodule : expansion_io_address_mapper_asserts

bind expansion_io_address_mapper expansion_io_address_mapper_asserts i_expansion_io_address_mapper_asserts (.*);
`default_nettype wire

// >>> testbench/expansion_chain_model.sv
// Behavioural model of the cascaded expansion modules
`timescale 1ns/10ps
`default_nettype none
module expansion_chain_model (
  // Clock, reset and configuration choice
  input  wire logic                 clock_in,
  input  wire logic                 rstn_in,
  input  wire logic [1:0]           mode_in,
  // Requests
  input  wire logic [5:0]           slot_in,
  input  wire mapper_pkg::exp_cmd_e cmd_in,
  input  wire logic [7:0]           index_in,
  input  wire logic [2:0]           word_in,
  input  wire logic [15:0]          wdata_in,
  // Answers
  output logic                      ack_out,
  output logic                      present_out,
  output var mapper_pkg::mod_kind_e kind_out,
  output logic                      decode_out,
  output logic      [7:0]           di_count_out,
  output logic      [7:0]           do_count_out,
  output logic      [3:0]           in_lanes_out,
  output logic      [3:0]           out_lanes_out,
  output logic      [15:0]          rdata_out
);
  import mapper_pkg::*;
  logic [1:0]  wait_ff;
  logic        slow_ff;
  logic [15:0] val;
  logic [15:0] out_words [int];
  logic        coils     [int];
  // Mode 0 legal chain, 1 too many input points, 2 too many modules
  always_comb begin
    {present_out, decode_out, di_count_out, do_count_out, in_lanes_out, out_lanes_out} = '0;
    kind_out = KIND_DIGITAL;
    present_out = (mode_in == 2'h2) || (slot_in < 6'h4);
    if (slot_in == 6'h0) begin
      di_count_out = (mode_in == 2'h1) ? 8'hfa : 8'h18;
      do_count_out = 8'h10;
    end else if (slot_in == 6'h1) begin
      di_count_out = 8'h0e;
      do_count_out = 8'h08;
    end else if (slot_in == 6'h2) begin
      kind_out     = KIND_ANALOG_IN;
      in_lanes_out = 4'h2;
    end else if (slot_in == 6'h3) begin
      kind_out      = KIND_SEG_DISP;
      decode_out    = 1'b1;
      out_lanes_out = 4'h2;
    end
    val = (cmd_in == CMD_RD_POINT) ? {15'h0, index_in[0] ^ slot_in[0]}
                                   : {4'hc, slot_in[3:0], index_in[3:0], 1'b0, word_in};
    // Data is only valid at the ack edge; otherwise show the inverse
    rdata_out = ack_out ? val : ~val;
  end
  // Alternates a prompt and a slow answer
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_out <= 1'b0;
      wait_ff <= 2'h0;
      slow_ff <= 1'b0;
    end else if (ack_out) begin
      ack_out <= 1'b0;
      wait_ff <= 2'h0;
      slow_ff <= ~slow_ff;
    end else if (cmd_in != CMD_IDLE) begin
      if (wait_ff == {slow_ff, 1'b0}) ack_out <= 1'b1;
      else wait_ff <= wait_ff + 2'h1;
    end
  end
  always @(posedge clock_in) begin
    if (ack_out && cmd_in == CMD_WR_WORD) out_words[slot_in * 256 + index_in * 8 + word_in] = wdata_in;
    if (ack_out && cmd_in == CMD_WR_POINT) coils[slot_in * 256 + index_in] = wdata_in[0];
  end
endmodule : expansion_chain_model
`default_nettype wire

// >>> testbench/expansion_io_address_mapper_tb_top.sv
// Testbench top of the expansion I/O address mapper
`timescale 1ns/10ps
`default_nettype none
module expansion_io_address_mapper_tb_top;
  import mapper_pkg::*;
  logic clock_in = 1'b0, rstn_in = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [255:0] coil_points = 256'h10020;
  logic [11:0] reg_addr = 12'h0;
  logic [15:0] reg_wdata = 16'h0, rdata, reg_rdata, exp_wdata;
  logic [5:0] slot, module_count;
  logic [7:0] idx, di_cnt, do_cnt;
  logic [2:0] word;
  logic [3:0] in_lanes, out_lanes, error_code;
  logic [255:0] in_points;
  logic ack, present, decode, reg_rvalid, map_ready, scan_done, error_flag;
  exp_cmd_e cmd;
  mod_kind_e kind;
  int error_cnt = 0;
  int n_checks = 0;
  always #2.5 clock_in = ~clock_in;

  expansion_io_address_mapper i_expansion_io_address_mapper (.clock_in(clock_in), .rstn_in(rstn_in),
    .exp_slot_out(slot), .exp_cmd_out(cmd), .exp_index_out(idx), .exp_word_out(word), .exp_wdata_out(exp_wdata),
    .exp_ack_in(ack), .exp_present_in(present), .exp_kind_in(kind), .exp_decode_in(decode),
    .exp_di_count_in(di_cnt), .exp_do_count_in(do_cnt), .exp_in_lanes_in(in_lanes), .exp_out_lanes_in(out_lanes),
    .exp_rdata_in(rdata), .input_points_out(in_points), .coil_points_in(coil_points), .reg_addr_in(reg_addr),
    .reg_rd_in(reg_rd), .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
    .reg_rvalid_out(reg_rvalid), .map_ready_out(map_ready), .scan_done_out(scan_done), .error_out(error_flag),
    .error_code_out(error_code), .module_count_out(module_count));
  expansion_chain_model i_expansion_chain_model (.clock_in(clock_in), .rstn_in(rstn_in), .mode_in(mode),
    .slot_in(slot), .cmd_in(cmd), .index_in(idx), .word_in(word), .wdata_in(exp_wdata), .ack_out(ack),
    .present_out(present), .kind_out(kind), .decode_out(decode), .di_count_out(di_cnt), .do_count_out(do_cnt),
    .in_lanes_out(in_lanes), .out_lanes_out(out_lanes), .rdata_out(rdata));

  // ****
  // Tasks and scenarios
  // ****
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic do_reset(input logic [1:0] m);
    @(posedge clock_in);
    mode <= m;
    rstn_in <= 1'b0;
    repeat (16) @(posedge clock_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 4000 && !map_ready && !error_flag; i++) @(posedge clock_in);
    #1;
  endtask : do_reset
  task automatic wait_scans(input int n);
    int seen;
    seen = 0;
    for (int i = 0; i < 4000 && seen < n; i++) begin
      @(posedge clock_in);
      #1;
      if (scan_done === 1'b1) seen++;
    end
    chk("scan passes", n, seen);
  endtask : wait_scans
  task automatic reg_read(input logic [11:0] a, input logic v, input logic [15:0] d);
    @(posedge clock_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock_in);
    reg_rd <= 1'b0;
    #1;
    chk("read valid", v, reg_rvalid);
    if (v) chk("read data", d, reg_rdata);
  endtask : reg_read
  task automatic reg_write(input logic [11:0] a, input logic [15:0] d);
    @(posedge clock_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock_in);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic test_discovery();
    do_reset(2'h0);
    chk("map ready", 1, map_ready);
    chk("module count", 4, module_count);
    chk("error flag", 0, error_flag);
    $display("test discovery done");
  endtask : test_discovery
  task automatic test_points();
    wait_scans(2);
    chk("input point 23", 1, in_points[23]);
    chk("input point 24", 0, in_points[24]);
    chk("input point 35", 1, in_points[35]);
    chk("coil slot0 5", 1, i_expansion_chain_model.coils[5]);
    chk("coil slot1 1", 1, i_expansion_chain_model.coils[257]);
    chk("coil slot1 8", 0, i_expansion_chain_model.coils[264]);
    $display("test points done");
  endtask : test_points
  task automatic test_in_bank();
    reg_read(12'hf00, 1'b1, 16'hc200);
    reg_read(12'hf01, 1'b1, 16'hc210);
    reg_read(12'hf40, 1'b0, 16'h0);
    reg_read(12'hed0, 1'b0, 16'h0);
    $display("test input bank done");
  endtask : test_in_bank
  task automatic test_out_bank();
    logic [15:0] vals [5];
    int k;
    vals = '{16'hffff, 16'h1234, 16'h0000, 16'h9876, 16'h0001};
    for (int i = 0; i < 5; i++) reg_write(12'hf40 + 12'(i), vals[i]);
    reg_write(12'hf00, 16'hdead);
    wait_scans(2);
    for (int i = 0; i < 5; i++) begin
      k = (i < 3) ? 768 + i : 776 + i - 3;
      chk("output lane word", vals[i], i_expansion_chain_model.out_words[k]);
    end
    chk("display lane1 word2", 0, i_expansion_chain_model.out_words.exists(778));
    reg_read(12'hf00, 1'b1, 16'hc200);
    $display("test output bank done");
  endtask : test_out_bank
  task automatic test_errors();
    do_reset(2'h1);
    chk("point error", 32'h11, {error_flag, error_code});
    do_reset(2'h2);
    chk("module error", 32'h15, {error_flag, error_code});
    $display("test errors done");
  endtask : test_errors

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  initial begin
    #50us;
    error_cnt++;
    end_of_test();
  end
  initial begin
    test_discovery();
    test_points();
    test_in_bank();
    test_out_bank();
    test_errors();
    end_of_test();
  end
endmodule : expansion_io_address_mapper_tb_top
`default_nettype wire
